//--- pkg/ipts_pkg.sv
// Constants for the interrupt pending, test and standby block.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package ipts_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_SRC = 5;
  localparam int ID_W = 3;
  localparam int NUM_KEY = 4;
  localparam int MAX_DEPTH = 2;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_REQ = 8'h04;
  localparam logic [7:0] OFF_ENA = 8'h08;
  localparam logic [7:0] OFF_GROUP = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_TEST = 8'h14;
  localparam logic [7:0] OFF_EDGE = 8'h18;
  localparam logic [7:0] OFF_STANDBY = 8'h1C;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_MIE_BIT = 0;
  localparam int STAT_IST_BIT = 0;
  localparam int STAT_DEPTH_LSB = 1;
  localparam int STAT_SVC_LSB = 4;
  localparam int TEST_WREQ_BIT = 0;
  localparam int TEST_EREQ_BIT = 1;
  localparam int TEST_WEN_BIT = 2;
  localparam int TEST_EEN_BIT = 3;
  localparam int SBY_LIGHT_BIT = 0;
  localparam int SBY_DEEP_BIT = 1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [NUM_SRC-1:0] RST_SRC = 5'h00;
  localparam logic [NUM_KEY-1:0] RST_EDGE_MODE = 4'h0;
  localparam logic [NUM_KEY-1:0] EDGE_MODE_PIN = 4'h0;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {IPTS_RUN, IPTS_LIGHT, IPTS_DEEP} ipts_sby_t;
endpackage

//--- src/ipts_pin_sync.sv
// Two-stage pin synchroniser with rising-edge pulse output.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ipts_pin_sync
  import ipts_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] pin_rise
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;

  // ****************************************
  // Synchroniser and edge compare
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign pin_level = sync_reg;
  assign pin_rise = sync_reg & ~prev_reg;
endmodule
`default_nettype wire

//--- src/ipts_top.sv
// Interrupt pending/priority, test sources and standby control.
// Assumes same-clock source pulses, core accept/return pulses, APB master.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ipts_top
  import ipts_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] src_fire,
  input wire logic watch_test_source,
  input wire logic ext_test_source,
  input wire logic [NUM_KEY-1:0] key_pins,
  input wire logic core_accept,
  input wire logic core_return_from_irq_instr,
  output logic service_req,
  output logic [ID_W-1:0] service_id,
  output logic standby_release,
  output logic cpu_clk_en,
  output logic osc_en
);
  // ****************************************
  // State
  // ****************************************
  logic master_irq_enable_reg;
  logic [NUM_SRC-1:0] source_request_flag_reg;
  logic [NUM_SRC-1:0] source_enable_flag_reg;
  logic [NUM_SRC-1:0] high_group_reg;
  logic in_service_status_low_bit_reg;
  logic [1:0] depth_reg;
  logic [MAX_DEPTH-1:0] stack_reg;
  logic watch_test_req_flag_reg;
  logic ext_test_req_flag_reg;
  logic watch_test_en_flag_reg;
  logic ext_test_en_flag_reg;
  logic [NUM_KEY-1:0] ext_test_edge_mode_reg;
  logic key_all_high_prev_reg;
  logic svc_req_reg;
  logic [ID_W-1:0] svc_id_reg;
  logic [31:0] prdata_reg;
  logic release_reg;
  ipts_sby_t sby_reg;
  ipts_sby_t sby_next;

  logic wr_en;
  logic setup;
  logic mapped;
  logic [31:0] rdata;
  logic ext_rise;
  logic [NUM_KEY-1:0] key_level;
  logic key_all_high;
  logic key_fall;
  logic ext_edge_pulse;
  logic [NUM_SRC-1:0] allow;
  logic [NUM_SRC-1:0] elig;
  logic [NUM_SRC-1:0] elig_high;
  logic accept;
  logic return_from_irq_instr;
  logic wake;

  // Lowest set bit wins: index 0 has the highest fixed priority
  function automatic logic [ID_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [ID_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = ID_W'(i);
      end
    end
    return idx;
  endfunction

  // ****************************************
  // Pin sampling
  // ****************************************
  ipts_pin_sync #(.WIDTH(1)) u_ext_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_async(ext_test_source),
    .pin_level(),
    .pin_rise(ext_rise)
  );

  ipts_pin_sync #(.WIDTH(NUM_KEY)) u_key_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_async(key_pins),
    .pin_level(key_level),
    .pin_rise()
  );

  // Selected keys ANDed: one low selected key masks the others
  assign key_all_high = &(key_level | ~ext_test_edge_mode_reg);
  assign key_fall = key_all_high_prev_reg & ~key_all_high;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_all_high_prev_reg <= 1'b1;
    end
    else
    begin
      key_all_high_prev_reg <= key_all_high;
    end
  end

  // Mode zero: pin rising edge; otherwise key falling edge
  assign ext_edge_pulse = (ext_test_edge_mode_reg == EDGE_MODE_PIN) ? ext_rise
                                                                    : key_fall;

  // ****************************************
  // APB slave
  // ****************************************
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  always_comb
  begin
    mapped = 1'b1;
    rdata = '0;
    unique case (paddr)
      OFF_CTRL: rdata[CTRL_MIE_BIT] = master_irq_enable_reg;
      OFF_REQ: rdata[NUM_SRC-1:0] = source_request_flag_reg;
      OFF_ENA: rdata[NUM_SRC-1:0] = source_enable_flag_reg;
      OFF_GROUP: rdata[NUM_SRC-1:0] = high_group_reg;
      OFF_STATUS:
      begin
        rdata[STAT_IST_BIT] = in_service_status_low_bit_reg;
        rdata[STAT_DEPTH_LSB +: 2] = depth_reg;
        rdata[STAT_SVC_LSB +: ID_W] = svc_id_reg;
      end
      OFF_TEST:
      begin
        rdata[TEST_WREQ_BIT] = watch_test_req_flag_reg;
        rdata[TEST_EREQ_BIT] = ext_test_req_flag_reg;
        rdata[TEST_WEN_BIT] = watch_test_en_flag_reg;
        rdata[TEST_EEN_BIT] = ext_test_en_flag_reg;
      end
      OFF_EDGE: rdata[NUM_KEY-1:0] = ext_test_edge_mode_reg;
      OFF_STANDBY:
      begin
        rdata[SBY_LIGHT_BIT] = (sby_reg == IPTS_LIGHT);
        rdata[SBY_DEEP_BIT] = (sby_reg == IPTS_DEEP);
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_reg <= '0;
    end
    else if (setup && !pwrite)
    begin
      prdata_reg <= rdata;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_irq_enable_reg <= 1'b0;
      source_enable_flag_reg <= RST_SRC;
      high_group_reg <= RST_SRC;
      ext_test_edge_mode_reg <= RST_EDGE_MODE;
      watch_test_en_flag_reg <= 1'b0;
      ext_test_en_flag_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        OFF_CTRL: master_irq_enable_reg <= pwdata[CTRL_MIE_BIT];
        OFF_ENA: source_enable_flag_reg <= pwdata[NUM_SRC-1:0];
        OFF_GROUP: high_group_reg <= pwdata[NUM_SRC-1:0];
        OFF_EDGE: ext_test_edge_mode_reg <= pwdata[NUM_KEY-1:0];
        OFF_TEST:
        begin
          watch_test_en_flag_reg <= pwdata[TEST_WEN_BIT];
          ext_test_en_flag_reg <= pwdata[TEST_EEN_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************
  // Test request flags
  // ****************************************
  // Write 0 clears a flag; a source event in the same cycle wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      watch_test_req_flag_reg <= 1'b0;
      ext_test_req_flag_reg <= 1'b0;
    end
    else
    begin
      if (watch_test_source)
      begin
        watch_test_req_flag_reg <= 1'b1;
      end
      else if (wr_en && paddr == OFF_TEST && !pwdata[TEST_WREQ_BIT])
      begin
        watch_test_req_flag_reg <= 1'b0;
      end
      if (ext_edge_pulse)
      begin
        ext_test_req_flag_reg <= 1'b1;
      end
      else if (wr_en && paddr == OFF_TEST && !pwdata[TEST_EREQ_BIT])
      begin
        ext_test_req_flag_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Vectored request flags and arbitration
  // ****************************************
  assign accept = core_accept && svc_req_reg;
  assign return_from_irq_instr = core_return_from_irq_instr && (depth_reg != 2'd0);

  // Status 1 or full depth blocks all; status 0 inside a routine below full depth lets only nesting group in
  always_comb
  begin
    if (in_service_status_low_bit_reg || depth_reg == 2'(MAX_DEPTH))
    begin
      allow = '0;
    end
    else if (depth_reg != 2'd0)
    begin
      allow = high_group_reg;
    end
    else
    begin
      allow = '1;
    end
  end

  assign elig = source_request_flag_reg & source_enable_flag_reg & allow
              & {NUM_SRC{master_irq_enable_reg}};
  assign elig_high = elig & high_group_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      source_request_flag_reg <= RST_SRC;
    end
    else
    begin
      for (int i = 0; i < NUM_SRC; i++)
      begin
        if (src_fire[i])
        begin
          source_request_flag_reg[i] <= 1'b1;
        end
        else if (accept && svc_id_reg == ID_W'(i))
        begin
          source_request_flag_reg[i] <= 1'b0;
        end
        else if (wr_en && paddr == OFF_REQ && pwdata[i])
        begin
          source_request_flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Picks a new winner each cycle; drops after an accept and stays low while status is 1
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      svc_req_reg <= 1'b0;
      svc_id_reg <= '0;
    end
    else
    begin
      svc_req_reg <= (|elig) && !accept && (sby_reg == IPTS_RUN);
      if (|elig_high)
      begin
        svc_id_reg <= first_set(elig_high);
      end
      else if (|elig)
      begin
        svc_id_reg <= first_set(elig);
      end
    end
  end

  assign service_req = svc_req_reg;
  assign service_id = svc_id_reg;

  // ****************************************
  // In-service status and nesting stack
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_service_status_low_bit_reg <= 1'b0;
      depth_reg <= 2'd0;
      stack_reg <= '0;
    end
    else if (accept)
    begin
      stack_reg[depth_reg[0]] <= in_service_status_low_bit_reg;
      depth_reg <= depth_reg + 2'd1;
      in_service_status_low_bit_reg <= 1'b1;
    end
    else if (return_from_irq_instr)
    begin
      in_service_status_low_bit_reg <= stack_reg[~depth_reg[0]];
      depth_reg <= depth_reg - 2'd1;
    end
    else if (wr_en && paddr == OFF_STATUS)
    begin
      in_service_status_low_bit_reg <= pwdata[STAT_IST_BIT];
    end
  end

  // ****************************************
  // Standby control
  // ****************************************
  // Test flags release standby but never enter arbitration
  assign wake = (|(source_request_flag_reg & source_enable_flag_reg))
              || (watch_test_req_flag_reg && watch_test_en_flag_reg)
              || (ext_test_req_flag_reg && ext_test_en_flag_reg);

  always_comb
  begin
    sby_next = sby_reg;
    if (sby_reg != IPTS_RUN && wake)
    begin
      sby_next = IPTS_RUN;
    end
    else if (sby_reg == IPTS_RUN && wr_en && paddr == OFF_STANDBY && !wake)
    begin
      if (pwdata[SBY_DEEP_BIT])
      begin
        sby_next = IPTS_DEEP;
      end
      else if (pwdata[SBY_LIGHT_BIT])
      begin
        sby_next = IPTS_LIGHT;
      end
    end
  end

  // Entering standby clears nothing: all flags and registers hold
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sby_reg <= IPTS_RUN;
      release_reg <= 1'b0;
    end
    else
    begin
      sby_reg <= sby_next;
      release_reg <= wake;
    end
  end

  assign standby_release = release_reg;
  assign cpu_clk_en = (sby_reg == IPTS_RUN);
  assign osc_en = (sby_reg != IPTS_DEEP);

  // ****************************************
  // Assertions
  // ****************************************
  a_pending_held: assert property (@(posedge clk) disable iff (!rst_n)
    (src_fire != '0) && !master_irq_enable_reg
    |=> ((source_request_flag_reg & $past(src_fire)) == $past(src_fire)) && !svc_req_reg)
    else $error("disabled source not held pending");

  a_enable_starts: assert property (@(posedge clk) disable iff (!rst_n)
    master_irq_enable_reg && !$past(master_irq_enable_reg) && !in_service_status_low_bit_reg
    && depth_reg == 2'd0 && (source_request_flag_reg & source_enable_flag_reg) != '0
    && sby_reg == IPTS_RUN |=> svc_req_reg)
    else $error("held enabled request not offered");

  a_low_order: assert property (@(posedge clk) disable iff (!rst_n)
    (elig_high == '0) && elig[0] |=> svc_id_reg == '0)
    else $error("fixed priority order broken");

  a_high_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (elig_high != '0) |=> high_group_reg[svc_id_reg])
    else $error("high group did not win");

  a_low_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    in_service_status_low_bit_reg |-> elig == '0)
    else $error("request let in at status 1");

  a_status_set: assert property (@(posedge clk) disable iff (!rst_n)
    accept |=> in_service_status_low_bit_reg && depth_reg == $past(depth_reg) + 2'd1)
    else $error("accept did not set status");

  a_status_back: assert property (@(posedge clk) disable iff (!rst_n)
    return_from_irq_instr && !accept |=> !in_service_status_low_bit_reg)
    else $error("return did not restore status");

  a_test_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    watch_test_req_flag_reg && !(wr_en && paddr == OFF_TEST) |=> watch_test_req_flag_reg)
    else $error("test flag cleared by itself");

  a_release_out: assert property (@(posedge clk) disable iff (!rst_n)
    ext_test_req_flag_reg && ext_test_en_flag_reg |=> standby_release)
    else $error("release missing for test source");

  a_key_mask: assert property (@(posedge clk) disable iff (!rst_n)
    ext_test_edge_mode_reg != EDGE_MODE_PIN && !key_all_high && !key_all_high_prev_reg
    && !ext_test_req_flag_reg && !(wr_en && paddr == OFF_EDGE) |=> !ext_test_req_flag_reg)
    else $error("flag set while selected key low");

  a_deep_osc: assert property (@(posedge clk) disable iff (!rst_n)
    sby_reg == IPTS_DEEP |-> !osc_en && !cpu_clk_en)
    else $error("deep standby left clocks on");

  a_wake_exit: assert property (@(posedge clk) disable iff (!rst_n)
    sby_reg != IPTS_RUN && wake |=> cpu_clk_en && osc_en)
    else $error("standby not released");
endmodule
`default_nettype wire

//--- verification/ipts_core_model.sv
// Core sequencer model: takes offered vectors and issues returns.
// Assumes a registered service_req and a bench that pulses return_from_irq_instr_go.
`timescale 1ns/1ps
`default_nettype none
module ipts_core_model
  import ipts_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic service_req,
  input wire logic [ID_W-1:0] service_id,
  input wire logic auto_en,
  input wire logic return_from_irq_instr_go,
  output logic core_accept,
  output logic core_return_from_irq_instr,
  output logic [ID_W-1:0] taken_id
);
  // ****************************************
  // Accept and return
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_accept <= 1'b0;
      core_return_from_irq_instr <= 1'b0;
      taken_id <= '0;
    end
    else
    begin
      // One-cycle take, held until the taking edge
      core_accept <= service_req && auto_en && !core_accept;
      core_return_from_irq_instr <= return_from_irq_instr_go;
      if (core_accept && service_req)
      begin
        taken_id <= service_id;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the interrupt, test and standby block.
// Assumes the core model answers offers; pins are driven here.
`timescale 1ns/1ps
`default_nettype none
module tb
  import ipts_pkg::*;
();
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_SRC-1:0] src_fire;
  logic [NUM_KEY-1:0] key_pins;
  logic watch_test_source, ext_test_source, core_accept, core_return_from_irq_instr;
  logic service_req, standby_release, cpu_clk_en, osc_en, auto_en, return_from_irq_instr_go;
  logic [ID_W-1:0] service_id, taken_id;
  int fail_count, compares;
  typedef struct packed {logic [4:0] fire; logic [4:0] grp; logic [2:0] id1; logic [2:0] id2;}
    ipts_row_t;
  ipts_row_t rows [3] = '{'{5'h03, 5'h00, 3'h0, 3'h1}, '{5'h0A, 5'h08, 3'h3, 3'h1},
    '{5'h14, 5'h10, 3'h4, 3'h2}};

  ipts_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_fire(src_fire), .watch_test_source(watch_test_source),
    .ext_test_source(ext_test_source), .key_pins(key_pins), .core_accept(core_accept),
    .core_return_from_irq_instr(core_return_from_irq_instr), .service_req(service_req), .service_id(service_id),
    .standby_release(standby_release), .cpu_clk_en(cpu_clk_en), .osc_en(osc_en));
  ipts_core_model core (.clk(clk), .rst_n(rst_n), .service_req(service_req),
    .service_id(service_id), .auto_en(auto_en), .return_from_irq_instr_go(return_from_irq_instr_go),
    .core_accept(core_accept), .core_return_from_irq_instr(core_return_from_irq_instr), .taken_id(taken_id));

  // ****************************************
  // Tasks
  // ****************************************
  task end_of_test();
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail_count++;
      end_of_test();
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: sig = core_accept & service_req;
      1: sig = cpu_clk_en;
      default: sig = standby_release;
    endcase
  endfunction

  task automatic wait_for(input int k);
    for (int n = 0; n < 60; n++)
    begin
      @(negedge clk);
      if (sig(k) === 1'b1) return;
    end
    fail_count++;
    end_of_test();
  endtask

  task automatic wait_acc(input logic [2:0] id);
    wait_for(0);
    @(negedge clk);
    chk("taken id", {29'h0, id}, {29'h0, taken_id});
  endtask

  task automatic pulse(input logic [NUM_SRC-1:0] m, input logic w);
    @(posedge clk);
    src_fire <= m;
    watch_test_source <= w;
    @(posedge clk);
    src_fire <= '0;
    watch_test_source <= 1'b0;
  endtask

  task automatic return_from_irq_instr();
    @(posedge clk);
    return_from_irq_instr_go <= 1'b1;
    @(posedge clk);
    return_from_irq_instr_go <= 1'b0;
    @(posedge clk);
  endtask

  task automatic test_rd(input logic [31:0] e);
    repeat (8) @(posedge clk);
    apb(1'b0, OFF_TEST, 32'h0);
    chk("test reg", e, rd);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    fail_count = 0;
    compares = 0;
    {rst_n, psel, penable, pwrite, paddr, pwdata, src_fire} = '0;
    {watch_test_source, ext_test_source, auto_en, return_from_irq_instr_go} = '0;
    key_pins = 4'hF;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    auto_en <= 1'b1;
    chk("cpu clk en", 32'h1, 32'(cpu_clk_en));
    for (int a = 0; a < 8; a++)
    begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk("reset reg", 32'h0, rd);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped slverr", 32'h1, 32'(err));
    // Held while disabled, then enabled
    apb(1'b1, OFF_ENA, 32'h1B);
    pulse(5'h06, 1'b0);
    repeat (8) @(posedge clk);
    chk("service req", 32'h0, 32'(service_req));
    apb(1'b1, OFF_CTRL, 32'h1);
    wait_acc(3'h1);
    return_from_irq_instr();
    apb(1'b1, OFF_ENA, 32'h1F);
    wait_acc(3'h2);
    return_from_irq_instr();
    foreach (rows[i])
    begin
      apb(1'b1, OFF_GROUP, {27'h0, rows[i].grp});
      pulse(rows[i].fire, 1'b0);
      wait_acc(rows[i].id1);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("status", 32'h3, {28'h0, rd[3:0]});
      return_from_irq_instr();
      wait_acc(rows[i].id2);
      return_from_irq_instr();
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("status", 32'h0, {28'h0, rd[3:0]});
    end
    // Nesting after software lowers status
    apb(1'b1, OFF_GROUP, 32'h01);
    pulse(5'h04, 1'b0);
    wait_acc(3'h2);
    auto_en <= 1'b0;
    pulse(5'h01, 1'b0);
    repeat (8) @(posedge clk);
    chk("service req", 32'h0, 32'(service_req));
    apb(1'b1, OFF_STATUS, 32'h0);
    repeat (4) @(negedge clk);
    chk("service id", 32'h0, 32'(service_id));
    auto_en <= 1'b1;
    wait_acc(3'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", 32'h5, {28'h0, rd[3:0]});
    return_from_irq_instr();
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", 32'h2, {28'h0, rd[3:0]});
    return_from_irq_instr();
    // Key mode, source disabled around the change
    apb(1'b1, OFF_TEST, 32'h0);
    apb(1'b1, OFF_EDGE, 32'h5);
    apb(1'b1, OFF_TEST, 32'h0);
    apb(1'b1, OFF_TEST, 32'h8);
    key_pins <= 4'hD;
    test_rd(32'h8);
    key_pins <= 4'hC;
    wait_for(2);
    test_rd(32'hA);
    apb(1'b1, OFF_TEST, 32'h8);
    key_pins <= 4'h8;
    test_rd(32'h8);
    key_pins <= 4'hF;
    apb(1'b1, OFF_TEST, 32'h0);
    apb(1'b1, OFF_EDGE, 32'h0);
    apb(1'b1, OFF_TEST, 32'h0);
    apb(1'b1, OFF_TEST, 32'h8);
    ext_test_source <= 1'b1;
    wait_for(2);
    test_rd(32'hA);
    chk("service req", 32'h0, 32'(service_req));
    ext_test_source <= 1'b0;
    // Watch source, gated and not self-clearing
    apb(1'b1, OFF_TEST, 32'h4);
    pulse(5'h00, 1'b1);
    wait_for(2);
    test_rd(32'h5);
    apb(1'b1, OFF_TEST, 32'h4);
    repeat (3) @(negedge clk);
    chk("release", 32'h0, 32'(standby_release));
    apb(1'b1, OFF_TEST, 32'h0);
    pulse(5'h00, 1'b1);
    test_rd(32'h1);
    chk("release", 32'h0, 32'(standby_release));
    // Standby entry, retention and exit
    apb(1'b1, OFF_EDGE, 32'h3);
    apb(1'b1, OFF_TEST, 32'h4);
    apb(1'b1, OFF_STANDBY, 32'h1);
    @(negedge clk);
    chk("cpu clk en", 32'h0, 32'(cpu_clk_en));
    chk("osc en", 32'h1, 32'(osc_en));
    apb(1'b0, OFF_EDGE, 32'h0);
    chk("edge mode", 32'h3, rd);
    pulse(5'h00, 1'b1);
    wait_for(1);
    apb(1'b1, OFF_TEST, 32'h4);
    apb(1'b1, OFF_STANDBY, 32'h2);
    @(negedge clk);
    chk("osc en", 32'h0, 32'(osc_en));
    chk("cpu clk en", 32'h0, 32'(cpu_clk_en));
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    chk("osc en", 32'h1, 32'(osc_en));
    @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFF_EDGE, 32'h0);
    chk("edge mode", 32'h0, rd);
    end_of_test();
  end
endmodule
`default_nettype wire
